// *** rtl/uac_cfg.svh ***
/*
 Constants of the dual-channel advanced control and reset block:
 register indices, field positions, reset values and reset timing.
 Assumes it is included by bare name from the package and the modules.
*/
`ifndef UAC_CFG_SVH
`define UAC_CFG_SVH
// ----------------------------------------
// Geometry
// ----------------------------------------
`define UAC_NCH 2
`define UAC_NREG 26
`define UAC_CH_BIT 7
// ----------------------------------------
// Register indices (byte address = 4 * index)
// ----------------------------------------
`define UAC_R_IER 5'h00
`define UAC_R_FCR 5'h01
`define UAC_R_ISR 5'h02
`define UAC_R_LCR 5'h03
`define UAC_R_MCR 5'h04
`define UAC_R_LSR 5'h05
`define UAC_R_MSR 5'h06
`define UAC_R_EXTRA_FEATURE_CONTROL_REG 5'h07
`define UAC_R_SPR 5'h08
`define UAC_R_DLL 5'h09
`define UAC_R_DLM 5'h0a
`define UAC_R_TXLVL 5'h0b
`define UAC_R_RXLVL 5'h0c
`define UAC_R_EFR 5'h0d
`define UAC_R_XON1 5'h0e
`define UAC_R_XON2 5'h0f
`define UAC_R_XOFF1 5'h10
`define UAC_R_XOFF2 5'h11
`define UAC_R_TXINT 5'h12
`define UAC_R_RXINT 5'h13
`define UAC_R_FLWH 5'h14
`define UAC_R_FLWL 5'h15
`define UAC_R_CLKP 5'h16
`define UAC_R_TURN 5'h17
`define UAC_R_AFC2 5'h18
`define UAC_R_AFC1 5'h19
// ----------------------------------------
// Field positions
// ----------------------------------------
`define UAC_AFC1_CONC 7
`define UAC_AFC1_SLPEDGE 4
`define UAC_AFC1_REMAP 2
`define UAC_AFC1_SRST 1
`define UAC_AFC1_TSRM 0
`define UAC_AFC2_TXDIS 2
`define UAC_IER_THR 1
`define UAC_IER_SLEEP 4
`define UAC_MCR_TRDY 0
`define UAC_MCR_RQS 1
`define UAC_MCR_OP2 2
`define UAC_MCR_IRQEN 3
`define UAC_EFR_AUTORX 6
`define UAC_EFR_AUTOTX 7
// ----------------------------------------
// Masks and reset values
// ----------------------------------------
`define UAC_AFC1_WMASK 8'h95
`define UAC_AFC2_WMASK 8'h3f
`define UAC_CLKP_WMASK 8'h0f
`define UAC_SPR_RST 8'h01
`define UAC_ISR_IDLE 8'h01
`define UAC_ISR_THR 8'h02
`define UAC_LSR_RST 8'h60
// ----------------------------------------
// Reset timing: crystal clocks per reset, pclk per crystal clock
// ----------------------------------------
`define UAC_RST_XTAL 4
`define UAC_PCLK_PER_XTAL 1
`define UAC_RST_CYC 3'((`UAC_RST_XTAL) * (`UAC_PCLK_PER_XTAL))
`endif

// *** rtl/uac_chan.sv ***
/*
 One channel core: sleep and wake, flow-control pin mapping,
 transmit-empty interrupt, modem status deltas, output pins.
 Assumes synchronised pin inputs and same-clock FIFO status inputs,
 and a synchronous channel reset from the top.
*/
`timescale 1ns/100ps
`include "uac_cfg.svh"
module uac_chan (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic chan_rst,
    input wire logic rx,
    input wire logic clear_send_n,
    input wire logic set_ready_n,
    input wire logic ring_n,
    input wire logic carrier_n,
    input wire logic msr_rd,
    input wire logic [7:0] interrupt_enable_reg,
    input wire logic [7:0] modem_control_reg,
    input wire logic [7:0] enhanced_feature_reg,
    input wire logic [7:0] afc1,
    input wire logic [7:0] afc2,
    input wire logic tx_bit,
    input wire logic tx_below_trig,
    input wire logic tx_fifo_empty,
    input wire logic tsr_empty,
    input wire logic rx_hold,
    input wire logic [4:0] rx_status,
    output logic serial_out,
    output logic request_send_n,
    output logic terminal_ready_n,
    output logic general_out_two_n,
    output logic irq_out,
    output logic irq_oe,
    output logic tx_halt,
    output logic sleeping,
    output logic [7:0] interrupt_status_reg,
    output logic [7:0] line_status_reg,
    output logic [7:0] modem_status_reg
);
    localparam uac_pkg::uac_chan_st_t CH_RST = '{
        slp: uac_pkg::UAC_AWAKE, rx_prev: 1'b1, mprev: 4'hf,
        mdelta: 4'h0, tx: 1'b1, rqs_n: 1'b1, trdy_n: 1'b1,
        op2_n: 1'b1, irq: 1'b0, irq_oe: 1'b0, halt: 1'b0,
        line_status_reg: `UAC_LSR_RST};
    uac_pkg::uac_chan_st_t r_q, r_d;
    logic [3:0] mnow;
    logic flow_n;
    logic peer_n;
    logic empty_ok;

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    assign mnow = {carrier_n, ring_n, set_ready_n, clear_send_n};
    always_comb begin
        r_d = r_q;
        r_d.rx_prev = rx;
        r_d.mprev = mnow;
        // A change seen in the read cycle survives the clear
        r_d.mdelta = (msr_rd ? 4'h0 : r_q.mdelta) | (r_q.mprev ^ mnow);
        case (r_q.slp)
            uac_pkg::UAC_AWAKE: begin
                // Level mode holds off sleep while the line is low
                if (interrupt_enable_reg[`UAC_IER_SLEEP] && (afc1[`UAC_AFC1_SLPEDGE] || rx)) begin
                    r_d.slp = uac_pkg::UAC_ASLEEP;
                end
            end
            uac_pkg::UAC_ASLEEP: begin
                if (!interrupt_enable_reg[`UAC_IER_SLEEP]) begin
                    r_d.slp = uac_pkg::UAC_AWAKE;
                end else if (afc1[`UAC_AFC1_SLPEDGE] ? (rx != r_q.rx_prev) : !rx) begin
                    r_d.slp = uac_pkg::UAC_AWAKE;
                end
            end
            default: r_d.slp = uac_pkg::UAC_AWAKE;
        endcase
        // Flow pin follows receive hold when automatic, else its control bit
        flow_n = enhanced_feature_reg[`UAC_EFR_AUTORX] ? rx_hold
            : ~(afc1[`UAC_AFC1_REMAP] ? modem_control_reg[`UAC_MCR_TRDY] : modem_control_reg[`UAC_MCR_RQS]);
        if (afc1[`UAC_AFC1_REMAP]) begin
            r_d.trdy_n = flow_n;
            r_d.rqs_n = ~modem_control_reg[`UAC_MCR_RQS];
        end else begin
            r_d.rqs_n = flow_n;
            r_d.trdy_n = ~modem_control_reg[`UAC_MCR_TRDY];
        end
        peer_n = afc1[`UAC_AFC1_REMAP] ? set_ready_n : clear_send_n;
        r_d.halt = enhanced_feature_reg[`UAC_EFR_AUTOTX] & peer_n;
        // Mode 1 waits for the last stop bit to leave the shifter
        empty_ok = afc1[`UAC_AFC1_TSRM] ? (tx_fifo_empty & tsr_empty)
            : tx_fifo_empty;
        r_d.irq = interrupt_enable_reg[`UAC_IER_THR] & (tx_below_trig | empty_ok);
        r_d.irq_oe = modem_control_reg[`UAC_MCR_IRQEN];
        r_d.tx = afc2[`UAC_AFC2_TXDIS] | tx_bit;
        r_d.op2_n = ~modem_control_reg[`UAC_MCR_OP2];
        r_d.line_status_reg = {1'b0, tx_fifo_empty & tsr_empty, tx_fifo_empty, rx_status};
        // Same values as the pin reset; pin history reloads to avoid false deltas
        if (chan_rst) begin
            r_d = CH_RST;
            r_d.mprev = mnow;
            r_d.rx_prev = rx;
        end
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_q <= CH_RST;
        end else begin
            r_q <= r_d;
        end
    end

    assign serial_out = r_q.tx;
    assign request_send_n = r_q.rqs_n;
    assign terminal_ready_n = r_q.trdy_n;
    assign general_out_two_n = r_q.op2_n;
    assign irq_out = r_q.irq;
    assign irq_oe = r_q.irq_oe;
    assign tx_halt = r_q.halt;
    assign sleeping = r_q.slp == uac_pkg::UAC_ASLEEP;
    assign interrupt_status_reg = r_q.irq ? `UAC_ISR_THR : `UAC_ISR_IDLE;
    assign line_status_reg = r_q.line_status_reg;
    // Upper half tracks the pins even in reset
    assign modem_status_reg = {~mnow, r_q.mdelta};
endmodule

// *** rtl/uac_pkg.sv ***
/*
 Types of the dual-channel advanced control and reset block.
 Assumes uac_cfg.svh is on the include path.
*/
`include "uac_cfg.svh"
package uac_pkg;
    // ----------------------------------------
    // Sleep state of one channel
    // ----------------------------------------
    typedef enum logic {
        UAC_AWAKE = 1'b0,
        UAC_ASLEEP = 1'b1
    } uac_sleep_t;
    // ----------------------------------------
    // State of one channel core
    // ----------------------------------------
    typedef struct packed {
        uac_sleep_t slp;
        logic rx_prev;
        logic [3:0] mprev;
        logic [3:0] mdelta;
        logic tx;
        logic rqs_n;
        logic trdy_n;
        logic op2_n;
        logic irq;
        logic irq_oe;
        logic halt;
        logic [7:0] line_status_reg;
    } uac_chan_st_t;
    // ----------------------------------------
    // State of the top: registers, reset counters, bus, synchronisers
    // ----------------------------------------
    typedef struct packed {
        logic [`UAC_NCH-1:0][`UAC_NREG-1:0][7:0] regs;
        logic [`UAC_NCH-1:0][2:0] rcnt;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic [`UAC_NCH-1:0][4:0] s1;
        logic [`UAC_NCH-1:0][4:0] s2;
    } uac_top_st_t;
endpackage

// *** rtl/uac_top.sv ***
/*
 Top of the dual-channel advanced control and reset block: APB slave,
 per-channel register file, soft and hard reset sequencing, pin
 synchronisers, and one channel core per channel.
 Assumes one clock pclk that also stands for the crystal clock, APB
 master on the same clock, FIFO status inputs on the same clock.
*/
// Notes on behaviour
// - With the concurrent-write bit set, a write lands in the same register of every channel.
// - In level mode a channel will not sleep while its line is low and wakes when it goes low.
// - In edge mode a channel may sleep with its line low and wakes on any toggle.
// - The remap bit moves hardware flow control onto the ready pair and frees the other pair.
// - Writing one to the soft reset bit resets the channel and the bit then reads back zero.
// - Every reset of a channel finishes within four crystal clocks.
// - In mode zero the transmit-empty interrupt fires below trigger or when the FIFO is empty.
// - In mode one the empty case also waits for the shift register to finish its stop bit.
// - Pin reset and soft reset bring registers and outputs to identical states.
// - Reset clears the control registers, sets scratch to one and zeroes the rest as well.
// - After reset the interrupt status reads one in bit zero, nothing pending.
// - After reset the line status shows the transmitter empty and nothing else.
// - After reset the modem status shows live pins above and cleared deltas below.
// - After reset serial, general, request and ready outputs are high and irq is undriven.
`timescale 1ns/100ps
`include "uac_cfg.svh"
module uac_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [`UAC_NCH-1:0] serial_in,
    input wire logic [`UAC_NCH-1:0] clear_send_n,
    input wire logic [`UAC_NCH-1:0] set_ready_n,
    input wire logic [`UAC_NCH-1:0] ring_n,
    input wire logic [`UAC_NCH-1:0] carrier_n,
    input wire logic [`UAC_NCH-1:0] tx_bit,
    input wire logic [`UAC_NCH-1:0] tx_below_trig,
    input wire logic [`UAC_NCH-1:0] tx_fifo_empty,
    input wire logic [`UAC_NCH-1:0] tsr_empty,
    input wire logic [`UAC_NCH-1:0] rx_hold,
    input wire logic [`UAC_NCH-1:0][4:0] rx_status,
    input wire logic [`UAC_NCH-1:0][7:0] tx_level,
    input wire logic [`UAC_NCH-1:0][7:0] rx_level,
    output logic [`UAC_NCH-1:0] serial_out,
    output logic [`UAC_NCH-1:0] request_send_n,
    output logic [`UAC_NCH-1:0] terminal_ready_n,
    output logic [`UAC_NCH-1:0] general_out_two_n,
    output logic [`UAC_NCH-1:0] irq_out,
    output logic [`UAC_NCH-1:0] irq_oe,
    output logic [`UAC_NCH-1:0] tx_halt,
    output logic [`UAC_NCH-1:0] sleeping
);
    // ----------------------------------------
    // Reset image
    // ----------------------------------------
    // Hard reset also loads the countdown, so both resets run one sequence
    function automatic uac_pkg::uac_top_st_t top_rst();
        uac_pkg::uac_top_st_t t;
        t = '0;
        for (int c = 0; c < `UAC_NCH; c++) begin
            t.regs[c][`UAC_R_SPR] = `UAC_SPR_RST;
            t.rcnt[c] = `UAC_RST_CYC;
            t.s1[c] = 5'h1f;
            t.s2[c] = 5'h1f;
        end
        return t;
    endfunction

    // Write mask per register; read-only ones take nothing
    function automatic logic [7:0] wmask(input logic [4:0] i);
        logic [7:0] m;
        m = 8'hff;
        case (i)
            `UAC_R_ISR, `UAC_R_LSR, `UAC_R_MSR: m = 8'h00;
            `UAC_R_TXLVL, `UAC_R_RXLVL: m = 8'h00;
            `UAC_R_AFC1: m = `UAC_AFC1_WMASK;
            `UAC_R_AFC2: m = `UAC_AFC2_WMASK;
            `UAC_R_CLKP: m = `UAC_CLKP_WMASK;
            default: m = 8'hff;
        endcase
        return m;
    endfunction

    localparam uac_pkg::uac_top_st_t TOP_RST = top_rst();

    uac_pkg::uac_top_st_t r_q, r_d;
    logic [`UAC_NCH-1:0] chan_rst;
    logic [`UAC_NCH-1:0] msr_rd;
    logic [`UAC_NCH-1:0][7:0] isr_v;
    logic [`UAC_NCH-1:0][7:0] lsr_v;
    logic [`UAC_NCH-1:0][7:0] msr_v;
    logic [4:0] idx;
    logic ch;
    logic acc;
    logic bad;
    logic wr;
    logic conc;
    logic [7:0] rdv;

    // ----------------------------------------
    // Address decode
    // ----------------------------------------
    assign idx = paddr[6:2];
    assign ch = paddr[`UAC_CH_BIT];
    assign acc = psel & penable;
    // Beyond the last index nothing answers but the error flag
    assign bad = idx >= 5'(`UAC_NREG);
    // Writes take effect only at the edge that completes the access
    assign wr = acc & r_q.pready & pwrite & ~r_q.pslverr;
    // Either channel's concurrent bit opens the broadcast
    assign conc = r_q.regs[0][`UAC_R_AFC1][`UAC_AFC1_CONC]
        | r_q.regs[1][`UAC_R_AFC1][`UAC_AFC1_CONC];

    // ----------------------------------------
    // Per-channel reset and delta-clear strobes
    // ----------------------------------------
    genvar g;
    generate
        for (g = 0; g < `UAC_NCH; g++) begin : g_ch
            // Nonzero countdown holds the channel in reset
            assign chan_rst[g] = r_q.rcnt[g] != 3'h0;
            assign msr_rd[g] = acc & r_q.pready & ~pwrite & (ch == 1'(g))
                & (idx == `UAC_R_MSR);

            uac_chan u_chan (
                .pclk(pclk),
                .presetn(presetn),
                .chan_rst(chan_rst[g]),
                .rx(r_q.s2[g][0]),
                .clear_send_n(r_q.s2[g][1]),
                .set_ready_n(r_q.s2[g][2]),
                .ring_n(r_q.s2[g][3]),
                .carrier_n(r_q.s2[g][4]),
                .msr_rd(msr_rd[g]),
                .interrupt_enable_reg(r_q.regs[g][`UAC_R_IER]),
                .modem_control_reg(r_q.regs[g][`UAC_R_MCR]),
                .enhanced_feature_reg(r_q.regs[g][`UAC_R_EFR]),
                .afc1(r_q.regs[g][`UAC_R_AFC1]),
                .afc2(r_q.regs[g][`UAC_R_AFC2]),
                .tx_bit(tx_bit[g]),
                .tx_below_trig(tx_below_trig[g]),
                .tx_fifo_empty(tx_fifo_empty[g]),
                .tsr_empty(tsr_empty[g]),
                .rx_hold(rx_hold[g]),
                .rx_status(rx_status[g]),
                .serial_out(serial_out[g]),
                .request_send_n(request_send_n[g]),
                .terminal_ready_n(terminal_ready_n[g]),
                .general_out_two_n(general_out_two_n[g]),
                .irq_out(irq_out[g]),
                .irq_oe(irq_oe[g]),
                .tx_halt(tx_halt[g]),
                .sleeping(sleeping[g]),
                .interrupt_status_reg(isr_v[g]),
                .line_status_reg(lsr_v[g]),
                .modem_status_reg(msr_v[g])
            );
        end
    endgenerate

    // ----------------------------------------
    // Read mux
    // ----------------------------------------
    // Always the addressed channel, even while broadcasting writes
    always_comb begin
        rdv = 8'h00;
        if (!bad) begin
            case (idx)
                `UAC_R_ISR: rdv = isr_v[ch];
                `UAC_R_LSR: rdv = lsr_v[ch];
                `UAC_R_MSR: rdv = msr_v[ch];
                // Live counts from the FIFOs, forced to zero during reset
                `UAC_R_TXLVL: rdv = chan_rst[ch] ? 8'h00 : tx_level[ch];
                `UAC_R_RXLVL: rdv = chan_rst[ch] ? 8'h00 : rx_level[ch];
                // Soft reset bit reads one only while the reset runs
                `UAC_R_AFC1: rdv = r_q.regs[ch][`UAC_R_AFC1]
                    | {6'h00, chan_rst[ch], 1'b0};
                default: rdv = r_q.regs[ch][idx];
            endcase
        end
    end

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        r_d = r_q;
        // Two-flop synchronisers: bits are rx, cts, dsr, ring, carrier
        for (int c = 0; c < `UAC_NCH; c++) begin
            r_d.s1[c] = {carrier_n[c], ring_n[c], set_ready_n[c],
                clear_send_n[c], serial_in[c]};
            r_d.s2[c] = r_q.s1[c];
        end
        // One wait state: answer is registered so outputs come from flops
        if (acc && !r_q.pready) begin
            r_d.pready = 1'b1;
            r_d.pslverr = bad;
            r_d.prdata = {24'h000000, rdv};
        end else begin
            r_d.pready = 1'b0;
            r_d.pslverr = 1'b0;
        end
        for (int c = 0; c < `UAC_NCH; c++) begin
            if (r_q.rcnt[c] != 3'h0) begin
                // Reset in progress: registers held at their reset image
                r_d.regs[c] = TOP_RST.regs[c];
                r_d.rcnt[c] = r_q.rcnt[c] - 3'h1;
            end else if (wr && (ch == c[0] || conc)) begin
                r_d.regs[c][idx] = (pwdata[7:0] & wmask(idx))
                    | (r_q.regs[c][idx] & ~wmask(idx));
                if (idx == `UAC_R_AFC1 && pwdata[`UAC_AFC1_SRST]) begin
                    r_d.rcnt[c] = `UAC_RST_CYC;
                end
            end
        end
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_q <= TOP_RST;
        end else begin
            r_q <= r_d;
        end
    end

    // ----------------------------------------
    // Bus outputs
    // ----------------------------------------
    assign prdata = r_q.prdata;
    assign pready = r_q.pready;
    assign pslverr = r_q.pslverr;
endmodule

// *** test/uac_line_peer.sv ***
/*
 Line-side model of one channel's transmitter: a burst drains the FIFO
 in 8 cycles and the last stop bit leaves the shift register 8 later.
 Assumes start is a one-cycle pulse on pclk.
*/
`timescale 1ns/100ps
module uac_line_peer (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic start,
    output logic tx_fifo_empty,
    output logic tsr_empty,
    output logic tx_bit
);
    logic [4:0] cnt_q;
    // Burst countdown; a fixed length keeps bench expectations simple
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) cnt_q <= 5'h00;
        else if (start) cnt_q <= 5'h10;
        else if (cnt_q != 5'h00) cnt_q <= cnt_q - 5'h01;
    end
    // Shift register still busy for 8 cycles after the FIFO empties
    assign tx_fifo_empty = cnt_q <= 5'h08;
    assign tsr_empty = cnt_q == 5'h00;
    assign tx_bit = (cnt_q == 5'h00) | cnt_q[0]; // Mark when idle
endmodule

// *** test/uac_top_assertions.sv ***
/*
 Port-level checker of uac_top: bus answer timing, read data shape,
 output states after reset release, transmit-empty interrupt cause.
 Assumes one clock pclk and the async active-low reset presetn.
*/
`timescale 1ns/100ps
`include "uac_cfg.svh"
module uac_top_assertions (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [`UAC_NCH-1:0] serial_out,
    input wire logic [`UAC_NCH-1:0] request_send_n,
    input wire logic [`UAC_NCH-1:0] terminal_ready_n,
    input wire logic [`UAC_NCH-1:0] general_out_two_n,
    input wire logic [`UAC_NCH-1:0] irq_out,
    input wire logic [`UAC_NCH-1:0] irq_oe,
    input wire logic [`UAC_NCH-1:0] tx_below_trig,
    input wire logic [`UAC_NCH-1:0] tx_fifo_empty,
    input wire logic [`UAC_NCH-1:0] sleeping
);
    // ----------------------------------------
    // Helper and properties
    // ----------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // All pins at their idle image, irq pin undriven
    wire out_idle = &{serial_out, request_send_n, terminal_ready_n, general_out_two_n}
        && irq_oe == '0 && irq_out == '0 && sleeping == '0;
    apb_wait_a: assert property (psel && !penable |=> !pready ##1 pready)
        else $error("bus answer not after one wait cycle");
    one_pulse_a: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    ready_req_a: assert property (pready |-> psel && penable)
        else $error("ready without a request");
    err_map_a: assert property (pready |-> pslverr == (paddr[6:2] >= 5'd26))
        else $error("error flag does not match the map");
    rd_width_a: assert property (pready |-> prdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    err_zero_a: assert property (pslverr |-> prdata == 32'h0)
        else $error("error read returned data");
    out_reset_a: assert property ($rose(presetn) |-> out_idle [*3])
        else $error("outputs left reset state early");
    irq_cause_a: assert property (
        (irq_out & ~$past(tx_below_trig | tx_fifo_empty)) == '0)
        else $error("interrupt without a cause");
endmodule
bind uac_top uac_top_assertions u_chk (.*);

// *** test/uac_top_tb_top.sv ***
/*
 Self-checking bench of uac_top: APB master tasks, one task per test.
 Assumes the peer model drives each channel's transmit status.
*/
`timescale 1ns/100ps
module uac_top_tb_top;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr;
    logic [1:0] serial_in = 2'h3, clear_send_n = 2'h3, set_ready_n = 2'h3, ring_n = 2'h3;
    logic [1:0] carrier_n = 2'h3, tx_below_trig = 2'h0, rx_hold = 2'h0, start = 2'h0;
    logic [1:0][4:0] rx_status = '0;
    logic [1:0][7:0] tx_level = '0, rx_level = '0;
    wire logic [1:0] tx_bit, tx_fifo_empty, tsr_empty;
    logic [1:0] serial_out, request_send_n, terminal_ready_n, general_out_two_n;
    logic [1:0] irq_out, irq_oe, tx_halt, sleeping;
    int n_errors = 0, cmp_count = 0, cyc = 0;
    uac_top u_dut (.*);
    for (genvar g = 0; g < 2; g++) begin : g_peer
        uac_line_peer u_peer (.pclk(pclk), .presetn(presetn), .start(start[g]),
            .tx_fifo_empty(tx_fifo_empty[g]), .tsr_empty(tsr_empty[g]), .tx_bit(tx_bit[g]));
    end
    // Clock, 25 ns period
    initial begin
        forever #12.5 pclk = ~pclk;
    end
    // Hang guard; the full run needs well under 3000 cycles
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 6000) begin
            n_errors++;
            summarize();
        end
    end
    // ----------------------------------------
    // Bus and compare tasks
    // ----------------------------------------
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // One idle edge first, so back-to-back calls never reassign psel in one step
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d,
        output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk iff pready === 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        cmp_count++;
        if (g !== x) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, g, x);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] x);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 8'h00, r, e);
        chk(r, {24'h0, x});
    endtask
    // Watch channel A's sleep flag for 8 cycles at the falling edge
    task automatic seen(input logic v, output logic s);
        s = 1'b0;
        repeat (8) begin
            @(negedge pclk);
            if (sleeping[0] === v) s = 1'b1;
        end
    endtask
    // ----------------------------------------
    // Tests
    // ----------------------------------------
    task automatic t_image(input logic c);
        for (int i = 0; i < 26; i++) begin
            rc({c, i[4:0], 2'b00}, (i == 8 || i == 2) ? 8'h01 : (i == 5) ? 8'h60 : 8'h00);
        end
        @(negedge pclk);
        chk(32'({serial_out, request_send_n, terminal_ready_n, general_out_two_n, irq_oe}),
            32'h3fc);
        $display("reset image of channel %0d done", c);
    endtask
    task automatic t_conc();
        logic [31:0] r;
        logic e;
        wr(8'h64, 8'h80);
        wr(8'h20, 8'h5a);
        rc(8'ha0, 8'h5a);
        wr(8'ha0, 8'h33);
        rc(8'h20, 8'h33);
        wr(8'h64, 8'h00);
        wr(8'ha0, 8'h44);
        rc(8'h20, 8'h33);
        rc(8'ha0, 8'h44);
        apb(1'b0, 8'h68, 8'h00, r, e);
        chk({r[30:0], e}, 32'h1);
        $display("concurrent write test done");
    endtask
    task automatic t_soft();
        wr(8'h20, 8'h77);
        wr(8'h10, 8'h04);
        // The pin register takes the new control bit one edge after the write
        repeat (2) @(negedge pclk);
        chk(32'(general_out_two_n), 32'h2);
        wr(8'h64, 8'h02);
        rc(8'h64, 8'h02);
        rc(8'h64, 8'h00);
        t_image(1'b0);
        rc(8'ha0, 8'h44);
        $display("soft reset test done");
    endtask
    task automatic t_sleep();
        logic s;
        @(posedge pclk);
        serial_in[0] <= 1'b0;
        wr(8'h00, 8'h10);
        seen(1'b1, s);
        chk(s, 1'b0);
        @(posedge pclk);
        serial_in[0] <= 1'b1;
        seen(1'b1, s);
        chk(s, 1'b1);
        @(posedge pclk);
        serial_in[0] <= 1'b0;
        seen(1'b0, s);
        chk(s, 1'b1);
        wr(8'h64, 8'h10);
        seen(1'b1, s);
        chk(s, 1'b1);
        @(posedge pclk);
        serial_in[0] <= 1'b1;
        seen(1'b0, s);
        chk(s, 1'b1);
        wr(8'h00, 8'h00);
        wr(8'h64, 8'h00);
        $display("sleep test done");
    endtask
    task automatic t_flow();
        wr(8'h10, 8'h03);
        wr(8'h34, 8'hc0);
        rx_hold[0] <= 1'b1;
        set_ready_n[0] <= 1'b0;
        repeat (5) @(negedge pclk);
        chk(32'({request_send_n[0], terminal_ready_n[0], tx_halt[0]}), 32'h5);
        wr(8'h64, 8'h04);
        repeat (5) @(negedge pclk);
        chk(32'({request_send_n[0], terminal_ready_n[0], tx_halt[0]}), 32'h2);
        rc(8'h18, 8'h22);
        rc(8'h18, 8'h20);
        @(posedge pclk);
        rx_hold[0] <= 1'b0;
        set_ready_n[0] <= 1'b1;
        wr(8'h34, 8'h00);
        wr(8'h64, 8'h00);
        $display("flow remap test done");
    endtask
    // Burst on channel A in mode m, below-trigger input bt
    task automatic t_irq(input logic m, input logic bt);
        wr(8'h00, 8'h02);
        wr(8'h64, {7'h0, m});
        @(posedge pclk);
        start[0] <= 1'b1;
        tx_below_trig[0] <= bt;
        @(posedge pclk);
        start[0] <= 1'b0;
        repeat (3) @(negedge pclk);
        chk(irq_out[0], bt);
        repeat (9) @(negedge pclk);
        chk(irq_out[0], bt | !m);
        repeat (8) @(negedge pclk);
        chk(irq_out[0], 1'b1);
        @(posedge pclk);
        tx_below_trig[0] <= 1'b0;
        $display("transmit empty test mode %0d done", m);
    endtask
    // Main sequence
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        repeat (5) @(posedge pclk);
        t_image(1'b0);
        t_image(1'b1);
        t_conc();
        t_soft();
        t_sleep();
        t_flow();
        t_irq(1'b0, 1'b0);
        t_irq(1'b1, 1'b0);
        t_irq(1'b1, 1'b1);
        summarize();
    end
endmodule
